// >>> roc_defs.svh
/*
 * Constants for the relay output channel control block: timing figures,
 * derived cycle counts and reset values.
 * Assumes a single 100 MHz clock and inclusion by bare name.
 */
`ifndef ROC_DEFS_SVH
`define ROC_DEFS_SVH


// ============================================================
// Clock
`define ROC_CLK_MHZ      100

// ============================================================
// Timing
`define ROC_CYCLE_US     6500
`define ROC_CYCLE_CLKS   (`ROC_CYCLE_US * `ROC_CLK_MHZ)
`define ROC_MS_US        1000
`define ROC_MS_CLKS      (`ROC_MS_US * `ROC_CLK_MHZ)
`define ROC_WD_MS        500
`define ROC_WD_FAILS     3
`define ROC_RESP_MS      20

// ============================================================
// Structure and reset values
`define ROC_CHANNELS     2
`define ROC_DLY_W        16
`define ROC_RST_OUT      1'b0

`endif

// >>> roc_pkg.sv
/*
 * Types and the error substitution function of the relay output block.
 * Assumes roc_defs.svh is available on the include path.
 */
`default_nettype none

package roc_pkg;

	// ============================================================
	// Error handling modes
	typedef enum logic [1:0]
	{
		ROC_ERR_CURRENT = 2'b00,
		ROC_ERR_SUBST   = 2'b01,
		ROC_ERR_LAST    = 2'b10
	} roc_err_mode_t;

	// ============================================================
	// Error substitution, used for every channel
	function automatic logic roc_err_apply(
		input roc_err_mode_t mode,
		input logic          err,
		input logic          src,
		input logic          subst,
		input logic          last
	);
		logic v;
		v = src;
		if (err)
		begin
			unique case (mode)
				ROC_ERR_CURRENT: v = src;
				ROC_ERR_SUBST:   v = subst;
				ROC_ERR_LAST:    v = last;
				// Unused code falls back to the safe substitute value
				default:         v = subst;
			endcase
		end
		return v;
	endfunction

endpackage

`default_nettype wire

// >>> roc_chan_if.sv
/*
 * Carrier between the channel conditioning logic and one delay stage.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface roc_chan_if #(parameter int DLY_W = 16);
	logic             target;
	logic             forceOff;
	logic             msTick;
	logic [DLY_W-1:0] onDly;
	logic [DLY_W-1:0] offDly;
	logic             out;

	modport ctl (output target, forceOff, msTick, onDly, offDly, input out);
	modport chn (input target, forceOff, msTick, onDly, offDly, output out);
endinterface

`default_nettype wire

// >>> roc_delay.sv
/*
 * ON/OFF delay stage and relay drive flop of one channel.
 * Assumes a one-cycle millisecond tick from the channel control logic.
 */
`timescale 1ns/1ps
`default_nettype none
`include "roc_defs.svh"

module roc_delay
	import roc_pkg::*;
#(
	parameter int DLY_W = `ROC_DLY_W
)
(
	input wire logic mclk,
	input wire logic rst_n,
	roc_chan_if.chn  ch
);

	typedef struct packed
	{
		logic             out;
		logic [DLY_W-1:0] cnt;
	} roc_dly_st_t;

	roc_dly_st_t s_q;
	roc_dly_st_t s_d;
	logic [DLY_W-1:0] dly;

	// ============================================================
	// Delay filter
	always_comb
	begin
		s_d = s_q;
		dly = ch.target ? ch.onDly : ch.offDly;
		if (ch.forceOff)
		begin
			s_d.out = 1'b0;
			s_d.cnt = '0;
		end
		else if (ch.target == s_q.out)
		begin
			// A pulse shorter than the delay never reaches the relay
			s_d.cnt = '0;
		end
		else if (dly == '0)
		begin
			s_d.out = ch.target;
		end
		else if (ch.msTick)
		begin
			if (s_q.cnt >= DLY_W'(dly - 1'b1))
			begin
				s_d.out = ch.target;
				s_d.cnt = '0;
			end
			else
			begin
				s_d.cnt = DLY_W'(s_q.cnt + 1'b1);
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q.out <= `ROC_RST_OUT;
			s_q.cnt <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign ch.out = s_q.out;

	// ============================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_on_delay;
		$rose(ch.out) |-> ($past(ch.onDly) == '0) ||
			($past(ch.msTick) && ($past(s_q.cnt) >= $past(ch.onDly) - 1'b1));
	endproperty
	a_on_delay: assert property (p_on_delay)
		else $error("Output rose before the ON delay ran out");

	property p_off_delay;
		($fell(ch.out) && !$past(ch.forceOff)) |->
			($past(ch.offDly) == '0) ||
			($past(ch.msTick) && ($past(s_q.cnt) >= $past(ch.offDly) - 1'b1));
	endproperty
	a_off_delay: assert property (p_off_delay)
		else $error("Output fell before the OFF delay ran out");

endmodule // roc_delay

`default_nettype wire

// >>> roc_top.sv
/*
 * Relay output channel control: com unit exchange cycle, watchdog,
 * source selection, error substitution, negation and relay drive.
 * Assumes all inputs come from logic on mclk; config ports are static
 * or change between exchanges.
 */
`timescale 1ns/1ps
`default_nettype none
`include "roc_defs.svh"

module roc_top
	import roc_pkg::*;
#(
	parameter int N          = `ROC_CHANNELS,
	parameter int DLY_W      = `ROC_DLY_W,
	parameter int CYCLE_CLKS = `ROC_CYCLE_CLKS,
	parameter int MS_CLKS    = `ROC_MS_CLKS,
	parameter int WD_MS      = `ROC_WD_MS
)
(
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             xferDone,
	input  wire logic             xferOk,
	input  wire logic [N-1:0]     busValue,
	input  wire logic [N-1:0]     busInvalid,
	input  wire logic             moduleActive,
	input  wire logic [N-1:0]     simMode,
	input  wire logic [N-1:0]     simValue,
	input  wire logic [N-1:0]     simInvalid,
	input  wire logic [2*N-1:0]   errMode,
	input  wire logic [N-1:0]     substValue,
	input  wire logic [N-1:0]     negate,
	input  wire logic [N*DLY_W-1:0] onDelayMs,
	input  wire logic [N*DLY_W-1:0] offDelayMs,
	output logic                  exchReq,
	output logic [N-1:0]          relayDrive,
	output logic [N-1:0]          chanError,
	output logic                  watchdogTripped
);

	localparam int CYC_W = $clog2(CYCLE_CLKS);
	localparam int MS_W  = $clog2(MS_CLKS);
	localparam int WD_W  = $clog2(WD_MS) + 1;

	// ============================================================
	// State
	typedef struct packed
	{
		logic [CYC_W-1:0] cycCnt;
		logic             exchReq;
		logic             waitAns;
		logic [MS_W-1:0]  msCnt;
		logic             msTick;
		logic [1:0]       failCnt;
		logic [WD_W-1:0]  wdCnt;
		logic             wdTrip;
		logic [N-1:0]     busVal;
		logic [N-1:0]     busInv;
		logic [N-1:0]     lastVal;
		logic [N-1:0]     chanErr;
		logic [N-1:0]     procVal;
		logic             forceOff;
	} roc_top_st_t;

	roc_top_st_t s_q;
	roc_top_st_t s_d;
	logic        cycWrap;
	logic        xferFail;
	logic        xferGood;
	logic        src;
	logic        srcInv;
	logic        err;
	logic        val;

	// ============================================================
	// Exchange cycle, watchdog and channel conditioning
	always_comb
	begin
		s_d = s_q;
		src = 1'b0;
		srcInv = 1'b0;
		err = 1'b0;
		val = 1'b0;

		// Fixed exchange cycle, independent of any measuring time
		cycWrap = (s_q.cycCnt == CYC_W'(CYCLE_CLKS - 1));
		s_d.cycCnt = cycWrap ? '0 : CYC_W'(s_q.cycCnt + 1'b1);
		s_d.exchReq = cycWrap;

		s_d.msTick = (s_q.msCnt == MS_W'(MS_CLKS - 1));
		s_d.msCnt = s_d.msTick ? '0 : MS_W'(s_q.msCnt + 1'b1);

		// A request left unanswered at the next cycle counts as failed
		xferGood = xferDone && xferOk;
		xferFail = (xferDone && !xferOk) ||
			(cycWrap && s_q.waitAns && !xferDone);
		if (cycWrap)
			s_d.waitAns = 1'b1;
		else if (xferDone)
			s_d.waitAns = 1'b0;

		if (xferGood)
		begin
			s_d.busVal = busValue;
			s_d.busInv = busInvalid;
			s_d.failCnt = '0;
			s_d.wdCnt = '0;
			s_d.wdTrip = 1'b0;
		end
		else
		begin
			if (xferFail && s_q.failCnt != 2'(`ROC_WD_FAILS))
				s_d.failCnt = 2'(s_q.failCnt + 1'b1);
			// Timer runs only once the failure run is complete
			if (s_q.failCnt == 2'(`ROC_WD_FAILS) && !s_q.wdTrip &&
				s_q.msTick)
			begin
				s_d.wdCnt = WD_W'(s_q.wdCnt + 1'b1);
				if (s_q.wdCnt == WD_W'(WD_MS - 1))
					s_d.wdTrip = 1'b1;
			end
		end

		// Only the data status and the watchdog raise an error; there is
		// no wiring fault input at all
		for (int i = 0; i < N; i++)
		begin
			src = simMode[i] ? simValue[i] : s_q.busVal[i];
			srcInv = simMode[i] ? simInvalid[i] : s_q.busInv[i];
			err = s_q.wdTrip || srcInv;
			val = roc_err_apply(roc_err_mode_t'(errMode[2*i +: 2]),
				err, src, substValue[i], s_q.lastVal[i]);
			if (!err)
				s_d.lastVal[i] = src;
			s_d.chanErr[i] = err;
			s_d.procVal[i] = val ^ negate[i];
		end

		// Module-wide active bit and watchdog both cut every relay
		s_d.forceOff = s_d.wdTrip || !moduleActive;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ============================================================
	// Delay stages; two register stages keep the response far below
	// the 20 ms limit when delays are zero
	generate
		for (genvar g = 0; g < N; g++)
		begin : g_chan
			roc_chan_if #(.DLY_W(DLY_W)) chIf ();

			assign chIf.target   = s_q.procVal[g];
			assign chIf.forceOff = s_q.forceOff;
			assign chIf.msTick   = s_q.msTick;
			assign chIf.onDly    = onDelayMs[g*DLY_W +: DLY_W];
			assign chIf.offDly   = offDelayMs[g*DLY_W +: DLY_W];

			roc_delay #(.DLY_W(DLY_W)) u_delay
			(
				.mclk  (mclk),
				.rst_n (rst_n),
				.ch    (chIf.chn)
			);

			assign relayDrive[g] = chIf.out;
		end
	endgenerate

	assign exchReq         = s_q.exchReq;
	assign chanError       = s_q.chanErr;
	assign watchdogTripped = s_q.wdTrip;

	// ============================================================
	// Checks, channel 0 standing for all
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_norm0;
		!simMode[0] ##1 !s_q.chanErr[0];
	endsequence

	sequence s_sim0;
		simMode[0] ##1 !s_q.chanErr[0];
	endsequence

	sequence s_err0(logic [1:0] m);
		(errMode[1:0] == m) ##1 s_q.chanErr[0];
	endsequence

	property p_wd_trip;
		$rose(s_q.wdTrip) |-> ($past(s_q.failCnt) == 2'(`ROC_WD_FAILS)) &&
			($past(s_q.wdCnt) == WD_W'(WD_MS - 1)) && $past(s_q.msTick);
	endproperty
	a_wd_trip: assert property (p_wd_trip)
		else $error("Watchdog tripped without full failure run and timeout");

	property p_wd_off;
		s_q.wdTrip |-> ##1 (relayDrive == '0);
	endproperty
	a_wd_off: assert property (p_wd_off)
		else $error("Relay still on after watchdog trip");

	property p_normal;
		s_norm0 |-> s_q.procVal[0] ==
			($past(s_q.busVal[0]) ^ $past(negate[0]));
	endproperty
	a_normal: assert property (p_normal)
		else $error("Normal mode did not pass the bus value");

	property p_sim;
		s_sim0 |-> s_q.procVal[0] == ($past(simValue[0]) ^ $past(negate[0]));
	endproperty
	a_sim: assert property (p_sim)
		else $error("Simulation mode did not pass the simulation value");

	property p_err;
		(s_q.wdTrip || (!simMode[0] && s_q.busInv[0]) ||
			(simMode[0] && simInvalid[0])) |=> s_q.chanErr[0];
	endproperty
	a_err: assert property (p_err)
		else $error("Error condition did not raise the channel error");

	property p_current;
		s_err0(ROC_ERR_CURRENT) |-> s_q.procVal[0] ==
			(($past(simMode[0]) ? $past(simValue[0]) :
			$past(s_q.busVal[0])) ^ $past(negate[0]));
	endproperty
	a_current: assert property (p_current)
		else $error("Current value mode changed the value");

	property p_subst;
		s_err0(ROC_ERR_SUBST) |-> s_q.procVal[0] ==
			($past(substValue[0]) ^ $past(negate[0]));
	endproperty
	a_subst: assert property (p_subst)
		else $error("Substitute value not applied during error");

	property p_last;
		s_err0(ROC_ERR_LAST) |-> s_q.procVal[0] ==
			($past(s_q.lastVal[0]) ^ $past(negate[0]));
	endproperty
	a_last: assert property (p_last)
		else $error("Last valid value not applied during error");

	property p_last_hold;
		s_q.chanErr[0] |=> $stable(s_q.lastVal[0]) || !s_q.chanErr[0];
	endproperty
	a_last_hold: assert property (p_last_hold)
		else $error("Last valid value changed while in error");

	property p_negate;
		(negate[0] && !simMode[0]) ##1 !s_q.chanErr[0] |->
			s_q.procVal[0] == !$past(s_q.busVal[0]);
	endproperty
	a_negate: assert property (p_negate)
		else $error("Negation did not invert the channel value");

	property p_inactive;
		!moduleActive |-> ##2 (relayDrive == '0);
	endproperty
	a_inactive: assert property (p_inactive)
		else $error("Relay on while module inactive");

	property p_cycle;
		$rose(s_q.exchReq) |-> $past(s_q.cycCnt) == CYC_W'(CYCLE_CLKS - 1);
	endproperty
	a_cycle: assert property (p_cycle)
		else $error("Exchange request off the fixed cycle");

	property p_response;
		($changed(s_q.procVal[0]) && !s_q.forceOff &&
			(onDelayMs[DLY_W-1:0] == '0) && (offDelayMs[DLY_W-1:0] == '0))
			|=> (relayDrive[0] == $past(s_q.procVal[0])) || s_q.forceOff;
	endproperty
	a_response: assert property (p_response)
		else $error("Relay did not follow an undelayed change");

	property p_fail_count;
		(xferDone && !xferOk && s_q.failCnt != 2'(`ROC_WD_FAILS)) |=>
			s_q.failCnt == 2'($past(s_q.failCnt) + 2'h1);
	endproperty
	a_fail_count: assert property (p_fail_count)
		else $error("Failed exchange not counted");

	property p_good_clear;
		(xferDone && xferOk) |=> (s_q.failCnt == 2'h0) && !s_q.wdTrip;
	endproperty
	a_good_clear: assert property (p_good_clear)
		else $error("Good exchange did not clear the watchdog");

	property p_off_hold;
		s_q.forceOff |=> (relayDrive == '0);
	endproperty
	a_off_hold: assert property (p_off_hold)
		else $error("Relay on while outputs are forced off");

endmodule // roc_top

`default_nettype wire

// >>> roc_com_model.sv
/*
 * Behavioural com unit that answers each exchange request of the block while mute is low.
 * Assumes the block's one-cycle exchReq pulse and a shared mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module roc_com_model
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       exchReq,
	input  wire logic       failMode,
	input  wire logic       slow,
	input  wire logic       mute,
	input  wire logic [1:0] valIn,
	input  wire logic [1:0] invIn,
	output logic            xferDone,
	output logic            xferOk,
	output logic [1:0]      busValue,
	output logic [1:0]      busInvalid
);
	int waitCnt;

	// ============================================================
	// Answer, prompt or slow; data lines scramble outside an answer
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			waitCnt    <= -1;
			xferDone   <= 1'b0;
			xferOk     <= 1'b0;
			busValue   <= 2'h0;
			busInvalid <= 2'h0;
		end
		else
		begin
			xferDone   <= 1'b0;
			xferOk     <= failMode;
			busValue   <= ~valIn;
			busInvalid <= ~invIn;
			if (exchReq && !mute)
				waitCnt <= slow ? 20 : 2;
			else if (waitCnt > 0)
				waitCnt <= waitCnt - 1;
			else if (waitCnt == 0)
			begin
				xferDone   <= 1'b1;
				xferOk     <= !failMode;
				busValue   <= valIn;
				busInvalid <= invIn;
				waitCnt    <= -1;
			end
		end
	end
endmodule // roc_com_model

`default_nettype wire

// >>> relay_output_channel_control_test.sv
/*
 * Self-checking bench for roc_top with a behavioural com unit.
 * Assumes shortened counts: 64-cycle exchange, 10-cycle ms, 5 ms watchdog.
 */
`timescale 1ns/1ps
`default_nettype none

module relay_output_channel_control_test;
	import roc_pkg::*;

	typedef struct {
		logic [1:0] sm, sv, si, bv, bi, sub, neg;
		logic [3:0] em;
		logic [1:0] er, ee;
	} roc_row_t;

	logic        mclk, rst_n, xferDone, xferOk, moduleActive;
	logic        failMode, slow, exchReq, watchdogTripped, mute;
	logic [1:0]  busValue, busInvalid, simMode, simValue, simInvalid;
	logic [1:0]  substValue, negate, valIn, invIn, relayDrive, chanError;
	logic [3:0]  errMode;
	logic [31:0] onDly, offDly;
	int          err_count, total_checks, cyc, n;
	roc_row_t    rows[9];

	roc_top #(.N(2), .DLY_W(16), .CYCLE_CLKS(64), .MS_CLKS(10), .WD_MS(5)) dut
	(
		.mclk(mclk), .rst_n(rst_n), .xferDone(xferDone), .xferOk(xferOk),
		.busValue(busValue), .busInvalid(busInvalid),
		.moduleActive(moduleActive), .simMode(simMode), .simValue(simValue),
		.simInvalid(simInvalid), .errMode(errMode), .substValue(substValue),
		.negate(negate), .onDelayMs(onDly), .offDelayMs(offDly),
		.exchReq(exchReq), .relayDrive(relayDrive), .chanError(chanError),
		.watchdogTripped(watchdogTripped)
	);

	roc_com_model com
	(
		.mclk(mclk), .rst_n(rst_n), .exchReq(exchReq), .failMode(failMode),
		.slow(slow), .mute(mute), .valIn(valIn), .invIn(invIn),
		.xferDone(xferDone),
		.xferOk(xferOk), .busValue(busValue), .busInvalid(busInvalid)
	);

	// ============================================================
	// Clock and timeout
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			err_count++;
			give_verdict();
		end
	end

	// ============================================================
	// Helpers
	task automatic step(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	// Steps until exchReq (0) or xferDone (1) is seen, bounded
	task automatic wait_for(input bit which, output int k);
		k = 0;
		do
		begin
			step(1);
			k++;
		end
		while (((which ? xferDone : exchReq) !== 1'b1) && k < 200);
		if (k >= 200)
			err_count++;
	endtask

	task automatic chk2(input string nm, input logic [1:0] e, logic [1:0] s);
		total_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic s);
		total_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %b seen %b", nm, e, s);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ============================================================
	// Main sequence
	initial
	begin
		{rst_n, failMode, slow, mute, simMode, simValue, simInvalid} = '0;
		{valIn, invIn, substValue, negate, errMode, onDly, offDly} = '0;
		moduleActive = 1'b1;
		err_count = 0;
		total_checks = 0;
		cyc = 0;
		// Fields: sm sv si bv bi sub neg em | relay error
		rows[0] = '{2'h0,2'h0,2'h0,2'h2,2'h0,2'h0,2'h0,4'h0,2'h2,2'h0};
		rows[1] = '{2'h0,2'h0,2'h0,2'h2,2'h0,2'h0,2'h3,4'h0,2'h1,2'h0};
		rows[2] = '{2'h3,2'h1,2'h0,2'h2,2'h0,2'h0,2'h0,4'h0,2'h1,2'h0};
		rows[3] = '{2'h0,2'h0,2'h0,2'h1,2'h0,2'h0,2'h0,4'h0,2'h1,2'h0};
		rows[4] = '{2'h0,2'h0,2'h0,2'h2,2'h3,2'h2,2'h0,4'h4,2'h2,2'h3};
		rows[5] = '{2'h0,2'h0,2'h0,2'h2,2'h3,2'h2,2'h0,4'ha,2'h1,2'h3};
		rows[6] = '{2'h3,2'h3,2'h1,2'h0,2'h0,2'h0,2'h0,4'h5,2'h2,2'h1};
		rows[7] = '{2'h0,2'h0,2'h0,2'h0,2'h3,2'h1,2'h0,4'hf,2'h1,2'h3};
		rows[8] = '{2'h0,2'h0,2'h0,2'h0,2'h3,2'h1,2'h3,4'h5,2'h2,2'h3};
		step(8);
		chk2("relayDrive", 2'h0, relayDrive);
		chk1("watchdogTripped", 1'b0, watchdogTripped);
		step(8);
		rst_n = 1'b1;
		wait_for(1'b0, n);
		wait_for(1'b0, n);
		chk1("exchPeriod", 1'b1, n == 64);
		// Table of ordinary cases, each settled by two exchanges
		foreach (rows[i])
		begin
			{simMode, simValue, simInvalid} = {rows[i].sm, rows[i].sv, rows[i].si};
			{valIn, invIn, substValue} = {rows[i].bv, rows[i].bi, rows[i].sub};
			{negate, errMode} = {rows[i].neg, rows[i].em};
			step(140);
			chk2("relayDrive", rows[i].er, relayDrive);
			chk2("chanError", rows[i].ee, chanError);
		end
		// ON and OFF delays of 3 ms on channel 0, driven by simulation value
		{invIn, negate, errMode, simValue} = '0;
		simMode = 2'h3;
		onDly = 32'h3;
		offDly = 32'h3;
		step(50);
		simValue = 2'h1;
		step(8);
		simValue = 2'h0;
		step(40);
		chk1("shortPulse", 1'b0, relayDrive[0]);
		simValue = 2'h1;
		step(15);
		chk1("onDelayEarly", 1'b0, relayDrive[0]);
		step(30);
		chk1("onDelayDone", 1'b1, relayDrive[0]);
		moduleActive = 1'b0;
		step(3);
		chk2("inactive", 2'h0, relayDrive);
		moduleActive = 1'b1;
		step(50);
		simValue = 2'h0;
		step(15);
		chk1("offDelayEarly", 1'b1, relayDrive[0]);
		step(30);
		chk1("offDelayDone", 1'b0, relayDrive[0]);
		// Watchdog after three failed exchanges
		{onDly, offDly, simMode} = '0;
		valIn = 2'h3;
		step(140);
		failMode = 1'b1;
		wait_for(1'b1, n);
		wait_for(1'b1, n);
		step(1);
		chk1("watchdogTripped", 1'b0, watchdogTripped);
		wait_for(1'b1, n);
		n = 0;
		while (watchdogTripped !== 1'b1 && n < 100)
		begin
			step(1);
			n++;
		end
		chk1("watchdogDelay", 1'b1, n >= 40 && n <= 62);
		step(2);
		chk2("relayDrive", 2'h0, relayDrive);
		chk2("chanError", 2'h3, chanError);
		failMode = 1'b0;
		slow = 1'b1;
		wait_for(1'b1, n);
		step(3);
		chk1("watchdogTripped", 1'b0, watchdogTripped);
		// Mute partner: unanswered requests must count as failures too
		mute = 1'b1;
		step(200);
		chk1("muteEarly", 1'b0, watchdogTripped);
		step(120);
		chk1("muteTrip", 1'b1, watchdogTripped);
		chk2("muteRelay", 2'h0, relayDrive);
		// Reset in mid-run, with the watchdog tripped
		rst_n = 1'b0;
		{mute, slow} = 2'h0;
		step(2);
		chk1("rstTrip", 1'b0, watchdogTripped);
		chk2("rstError", 2'h0, chanError);
		rst_n = 1'b1;
		step(1);
		chk2("rstRelay", 2'h0, relayDrive);
		chk1("rstExch", 1'b0, exchReq);
		wait_for(1'b0, n);
		chk1("exchAfterRst", 1'b1, n == 63);
		step(8);
		chk2("relayAfterRst", 2'h3, relayDrive);
		give_verdict();
	end
endmodule // relay_output_channel_control_test

`default_nettype wire
